// ===== verilog/cfr_pkg.sv
/*
  cfr_pkg: constants and types shared by the cache fill / replace /
  write-allocate controller. Assumes a 32-bit byte address and a
  Wishbone register slave with 32-bit data.
*/
package cfr_pkg;
  // register byte offsets
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_PURGE   = 4'h4;
  localparam logic [3:0] REG_STATUS  = 4'h8;
  localparam logic [3:0] REG_COUNT   = 4'hC;
  // control field positions
  localparam int CTRL_CD   = 0;
  localparam int CTRL_NW   = 1;
  localparam int CTRL_L2D  = 2;
  localparam int CTRL_WBI  = 8;
  localparam int CTRL_INV  = 9;
  localparam int PURGE_WB  = 0;
  localparam int PAGE_LSB  = 12;
  // reset values
  localparam logic CD_RST  = 1'b0;
  localparam logic NW_RST  = 1'b0;
  localparam logic L2D_RST = 1'b0;
  // burst length of a 32-byte line fill
  localparam logic [2:0] BURST_BEATS = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_WB    = 4'h1,
    ST_INV   = 4'h2,
    ST_FACK  = 4'h3,
    ST_LOOK  = 4'h4,
    ST_VICT  = 4'h5,
    ST_FILL  = 4'h6,
    ST_SWR   = 4'h7,
    ST_DONE  = 4'h8
  } cfr_state_t;

  typedef enum logic [1:0] {
    FL_ALL   = 2'h0,
    FL_PAGE  = 2'h1,
    FL_NONE  = 2'h2
  } cfr_flush_t;
endpackage

// ===== verilog/cfr_ctrl.sv
/*
  cfr_ctrl: control logic for a two-level cache: disabling, flushing,
  cacheability decisions, burst line fills, sector fills, victim
  writeback, replacement choice and write allocate.
  Assumes: tag lookups are answered combinationally on the l1_ and l2_
  lookup inputs;
  the array datapath follows the one-cycle command pulses; the bus
  partner answers with burst_ready_n and cacheable_ack_n.
*/
// Behaviour
// - flush input: write back modified lines, invalidate all, then acknowledge
// - writeback-invalidate writes modified lines first; invalidate-only skips
// - page purge register write invalidates one 4-Kbyte page, optional writeback
// - second level disable keeps L2 untouched for every purpose
// - second level disable bit resets to zero
// - no control exists to disable L1 alone
// - accesses are cacheable unless marked uncacheable; write-combining is uncacheable
// - locked never cached; table walks skip L1 but may enter L2
// - cacheable read: intent output, four ready strobes; else single transfer
// - L1 miss fills from L2 hit, else bus; bus lines go to both
// - tag-miss fill invalidates the sector's unrequested line
// - tag-hit fill leaves the other sector line in its state
// - modified victim goes to L2 on hit as modified, else bus only
// - other modified sector line written back alike; L2 copy marked modified on hit
// - L1 instruction and L2 victims chosen least-recently-used on read misses
// - L1 data victims chosen least-recently-allocated
// - write allocate fetches from L2 or bus burst, merges, stores in L1
// - memory line goes to L2 unmerged; exclusive if L1 modified, else shared
// - cacheable ack negated on allocate fetch at first ready, not at next address: single bus write instead
// - write allocate taken when any enabling mechanism reports cacheable
// - cache_disable_bit set with not_writethrough clear stops fills, keeps contents
`timescale 1ns/1ps
module cfr_ctrl #(
  parameter int WAYS = 2
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // flush request pin, active low
  input  wire logic        flush_n_i,
  // core access request
  input  wire logic        req_i,
  input  wire logic        req_we_i,
  input  wire logic        req_instr_i,
  input  wire logic        req_locked_i,
  input  wire logic        req_walk_i,
  input  wire logic        req_uncache_i,
  input  wire logic        req_wa_ok_i,
  input  wire logic [31:0] req_adr_i,
  // lookup results
  input  wire logic        l1_tag_hit_i,
  input  wire logic        l1_line_valid_i,
  input  wire logic        l1_victim_mod_i,
  input  wire logic        l1_other_mod_i,
  input  wire logic        l2_hit_i,
  input  wire logic        wb_policy_i,
  input  wire logic        dirty_left_i,
  input  wire logic        lines_left_i,
  // system bus
  input  wire logic        burst_ready_n_i,
  input  wire logic        next_address_n_i,
  input  wire logic        cacheable_ack_n_i,
  output logic             bus_start_o,
  output logic             bus_we_o,
  output logic             line_fill_intent_o,
  output logic             flush_ack_cycle_o,
  output logic [31:0]      bus_adr_o,
  // array commands, one-cycle pulses; page_mode_o, use_lru_o and victim_way_o are held levels
  output logic             l1_fill_o,
  output logic             l1_inv_other_o,
  output logic             l1_merge_o,
  output logic             l2_fill_o,
  output logic             l2_shared_o,
  output logic             l2_mark_mod_o,
  output logic             step_wb_o,
  output logic             step_inv_o,
  output logic             page_mode_o,
  output logic             use_lru_o,
  output logic [WAYS-1:0]  victim_way_o,
  output logic             req_done_o
);
  initial begin
    if (WAYS < 2 || WAYS > 8) $error("cfr_ctrl: WAYS must be 2..8");
  end

  typedef struct packed {
    cfr_pkg::cfr_state_t st;
    cfr_pkg::cfr_flush_t fmode;
    logic                cd;
    logic                nw;
    logic                l2d;
    logic                purge_wb;
    logic                fl_wb;
    logic                fl_pin;
    logic [19:0]         page;
    logic                busy;
    logic                ack;
    logic [31:0]         rdat;
    logic [2:0]          beats;
    logic                ken_seen;
    logic                ken_ok;
    logic                walk;
    logic                we;
    logic [WAYS-1:0]     lra;
    logic [WAYS-1:0]     lru;
    logic [15:0]         fills;
    logic                bus_start;
    logic                bus_we;
    logic                intent;
    logic                fack;
    logic [31:0]         adr;
    logic                l1_fill;
    logic                l1_inv_other;
    logic                l1_merge;
    logic                l2_fill;
    logic                l2_shared;
    logic                l2_mark_mod;
    logic                step_wb;
    logic                step_inv;
    logic                done;
    logic                vic_wb;
    logic                pmode;
    logic                use_lru;
    logic [WAYS-1:0]     victim;
  } cfr_reg_t;

  cfr_reg_t r;
  cfr_reg_t next_r;

  // one-hot rotate used for both replacement pointers
  function automatic logic [WAYS-1:0] rot(input logic [WAYS-1:0] v);
    rot = {v[WAYS-2:0], v[WAYS-1]};
  endfunction

  logic sel_ctrl;
  logic sel_purge;
  logic wb_hit;
  logic ready;
  logic l2_use;
  logic cacheable;

  assign wb_hit    = wb_cyc_i && wb_stb_i && !r.ack;
  assign sel_ctrl  = wb_hit && wb_we_i && wb_adr_i == cfr_pkg::REG_CTRL
                     && wb_sel_i[0];
  assign sel_purge = wb_hit && wb_we_i && wb_adr_i == cfr_pkg::REG_PURGE;
  assign ready     = !burst_ready_n_i;
  assign l2_use    = !r.l2d && l2_hit_i;
  // uncacheable marks by software, locked, cache disable bit
  assign cacheable = !req_uncache_i && !req_locked_i && !r.cd;

  // whole next-state computation in one place
  always_comb begin
    next_r = r;
    next_r.bus_start    = 1'b0;
    next_r.l1_fill      = 1'b0;
    next_r.l1_inv_other = 1'b0;
    next_r.l1_merge     = 1'b0;
    next_r.l2_fill      = 1'b0;
    next_r.l2_shared    = 1'b0;
    next_r.l2_mark_mod  = 1'b0;
    next_r.step_wb      = 1'b0;
    next_r.step_inv     = 1'b0;
    next_r.fack         = 1'b0;
    next_r.done         = 1'b0;
    next_r.ack          = wb_hit;

    // register reads, unmapped offsets read zero
    next_r.rdat = 32'h0000_0000;
    unique case (wb_adr_i)
      cfr_pkg::REG_CTRL:   next_r.rdat = {29'h0, r.l2d, r.nw, r.cd};
      cfr_pkg::REG_PURGE:  next_r.rdat = {r.page, 11'h0, r.purge_wb};
      cfr_pkg::REG_STATUS: next_r.rdat = {27'h0, r.busy, r.st};
      cfr_pkg::REG_COUNT:  next_r.rdat = {16'h0, r.fills};
      default:             next_r.rdat = 32'h0000_0000;
    endcase

    // control writes; there is deliberately no L1-only disable
    if (sel_ctrl) begin
      next_r.cd  = wb_dat_i[cfr_pkg::CTRL_CD];
      next_r.nw  = wb_dat_i[cfr_pkg::CTRL_NW];
      next_r.l2d = wb_dat_i[cfr_pkg::CTRL_L2D];
    end

    unique case (r.st)
      cfr_pkg::ST_IDLE: begin
        if (!flush_n_i) begin
          next_r.st     = cfr_pkg::ST_WB;
          next_r.fmode  = cfr_pkg::FL_ALL;
          next_r.fl_wb  = 1'b1;
          next_r.fl_pin = 1'b1;
          next_r.busy   = 1'b1;
        end else if (sel_ctrl && wb_sel_i[1] &&
                     (wb_dat_i[cfr_pkg::CTRL_WBI] ||
                      wb_dat_i[cfr_pkg::CTRL_INV])) begin
          next_r.fl_wb  = wb_dat_i[cfr_pkg::CTRL_WBI];
          next_r.fl_pin = 1'b0;
          next_r.fmode  = cfr_pkg::FL_ALL;
          next_r.st     = wb_dat_i[cfr_pkg::CTRL_WBI] ?
                          cfr_pkg::ST_WB : cfr_pkg::ST_INV;
          next_r.busy   = 1'b1;
        end else if (sel_purge) begin
          next_r.page     = wb_dat_i[31:cfr_pkg::PAGE_LSB];
          next_r.purge_wb = wb_dat_i[cfr_pkg::PURGE_WB];
          next_r.fl_wb    = wb_dat_i[cfr_pkg::PURGE_WB];
          next_r.fl_pin   = 1'b0;
          next_r.fmode    = cfr_pkg::FL_PAGE;
          next_r.st       = wb_dat_i[cfr_pkg::PURGE_WB] ?
                            cfr_pkg::ST_WB : cfr_pkg::ST_INV;
          next_r.busy     = 1'b1;
        end else if (req_i) begin
          next_r.adr  = req_adr_i;
          next_r.we   = req_we_i;
          next_r.walk = req_walk_i;
          next_r.st   = cfr_pkg::ST_LOOK;
          next_r.busy = 1'b1;
        end
      end
      // walk of modified lines, one writeback step per cycle
      cfr_pkg::ST_WB: begin
        if (dirty_left_i) begin
          next_r.step_wb = 1'b1;
        end else begin
          next_r.st = cfr_pkg::ST_INV;
        end
      end
      cfr_pkg::ST_INV: begin
        if (lines_left_i) begin
          next_r.step_inv = 1'b1;
        end else begin
          next_r.st = r.fl_pin ? cfr_pkg::ST_FACK : cfr_pkg::ST_DONE;
        end
      end
      cfr_pkg::ST_FACK: begin
        next_r.fack = 1'b1;
        next_r.st   = cfr_pkg::ST_DONE;
      end
      cfr_pkg::ST_LOOK: begin
        if (l1_tag_hit_i && l1_line_valid_i) begin
          next_r.st = cfr_pkg::ST_DONE;
        end else if (!cacheable || (r.we && !req_wa_ok_i)) begin
          // single transfer; write allocate needs a mechanism
          next_r.bus_start = 1'b1;
          next_r.bus_we    = r.we;
          next_r.intent    = 1'b0;
          next_r.beats     = 3'h0;
          next_r.st        = cfr_pkg::ST_SWR;
        end else begin
          next_r.st = cfr_pkg::ST_VICT;
        end
      end
      // displaced modified lines, one a cycle: victim, then the other
      // line of the sector; to L2 on hit, else bus
      cfr_pkg::ST_VICT: begin
        if ((l1_victim_mod_i && !r.vic_wb) || l1_other_mod_i) begin
          if (l2_use) begin
            next_r.l2_mark_mod = 1'b1;
          end else begin
            next_r.step_wb = 1'b1;
          end
        end
        if (l1_victim_mod_i && l1_other_mod_i && !r.vic_wb) begin
          next_r.vic_wb = 1'b1; // other line goes next cycle
        end else if (l2_use && !r.walk) begin
          next_r.vic_wb       = 1'b0;
          next_r.l1_fill      = 1'b1;
          next_r.l1_merge     = r.we;
          next_r.l1_inv_other = !l1_tag_hit_i;
          next_r.st           = cfr_pkg::ST_DONE;
        end else begin
          next_r.vic_wb    = 1'b0;
          next_r.bus_start = 1'b1;
          next_r.bus_we    = 1'b0;
          next_r.intent    = 1'b1;
          next_r.beats     = 3'h0;
          next_r.ken_seen  = 1'b0;
          next_r.ken_ok    = 1'b0;
          next_r.st        = cfr_pkg::ST_FILL;
        end
      end
      cfr_pkg::ST_FILL: begin
        if (!r.ken_seen && (ready || !next_address_n_i)) begin
          next_r.ken_seen = 1'b1;
          next_r.ken_ok   = !cacheable_ack_n_i;
        end
        if (ready) begin
          next_r.beats = r.beats + 3'h1;
          if (!r.ken_seen && cacheable_ack_n_i) begin
            // partner refused: a read ends here, a write goes single
            next_r.intent = 1'b0;
            if (r.we) begin
              next_r.bus_start = 1'b1;
              next_r.bus_we    = 1'b1;
              next_r.beats     = 3'h0;
              next_r.st        = cfr_pkg::ST_SWR;
            end else begin
              next_r.st = cfr_pkg::ST_DONE;
            end
          end else if (r.beats + 3'h1 == cfr_pkg::BURST_BEATS) begin
            next_r.intent       = 1'b0;
            next_r.l1_fill      = !r.walk;
            next_r.l1_merge     = r.we && !r.walk;
            next_r.l1_inv_other = !l1_tag_hit_i;
            next_r.l2_fill      = !r.l2d;
            next_r.l2_shared    = !r.l2d && r.we && !wb_policy_i;
            next_r.fills        = r.fills + 16'h1;
            next_r.st           = cfr_pkg::ST_DONE;
          end
        end
      end
      cfr_pkg::ST_SWR: begin
        if (ready) begin
          next_r.st = cfr_pkg::ST_DONE;
        end
      end
      cfr_pkg::ST_DONE: begin
        // replacement pointers advance on allocation
        if (r.l1_fill) begin
          if (r.we || !req_instr_i) begin
            next_r.lra = rot(r.lra);
          end else begin
            next_r.lru = rot(r.lru);
          end
        end
        next_r.done = r.fmode == cfr_pkg::FL_NONE;
        next_r.fmode = cfr_pkg::FL_NONE;
        next_r.busy = 1'b0;
        next_r.st   = cfr_pkg::ST_IDLE;
      end
      default: next_r.st = cfr_pkg::ST_IDLE;
    endcase

    // registered views so these outputs come from flops
    next_r.pmode   = next_r.fmode == cfr_pkg::FL_PAGE;
    next_r.use_lru = !next_r.we && req_instr_i;
    next_r.victim  = next_r.use_lru ? next_r.lru : next_r.lra;
  end

  // single state register; synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r       <= '0;
      r.cd    <= cfr_pkg::CD_RST;
      r.nw    <= cfr_pkg::NW_RST;
      r.l2d   <= cfr_pkg::L2D_RST;
      r.fmode <= cfr_pkg::FL_NONE;
      r.st    <= cfr_pkg::ST_IDLE;
      r.lra   <= {{(WAYS-1){1'b0}}, 1'b1};
      r.lru   <= {{(WAYS-1){1'b0}}, 1'b1};
      r.victim <= {{(WAYS-1){1'b0}}, 1'b1};
    end else begin
      r <= next_r;
    end
  end

  // all outputs straight from the state register
  assign wb_dat_o           = r.rdat;
  assign wb_ack_o           = r.ack;
  assign bus_start_o        = r.bus_start;
  assign bus_we_o           = r.bus_we;
  assign line_fill_intent_o = r.intent;
  assign flush_ack_cycle_o  = r.fack;
  assign bus_adr_o          = r.adr;
  assign l1_fill_o          = r.l1_fill;
  assign l1_inv_other_o     = r.l1_inv_other;
  assign l1_merge_o         = r.l1_merge;
  assign l2_fill_o          = r.l2_fill;
  assign l2_shared_o        = r.l2_shared;
  assign l2_mark_mod_o      = r.l2_mark_mod;
  assign step_wb_o          = r.step_wb;
  assign step_inv_o         = r.step_inv;
  assign page_mode_o        = r.pmode;
  assign use_lru_o          = r.use_lru;
  assign victim_way_o       = r.victim;
  assign req_done_o         = r.done;
endmodule // cfr_ctrl

// ===== verif/cfr_ctrl_properties.sv
/* cfr_ctrl_chk: bound checker for cfr_ctrl register bus, flush and
   cacheability behaviour. Assumes control writes never overlap an
   access, so a copy of the control bits lagging by a cycle is exact. */
`timescale 1ns/1ps
module cfr_ctrl_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        req_i,
  input wire logic        req_locked_i,
  input wire logic        req_walk_i,
  input wire logic        req_uncache_i,
  input wire logic        req_done_o,
  input wire logic        burst_ready_n_i,
  input wire logic        line_fill_intent_o,
  input wire logic        flush_ack_cycle_o,
  input wire logic        l1_fill_o,
  input wire logic        l2_fill_o,
  input wire logic        l2_shared_o,
  input wire logic        l2_mark_mod_o
);
  logic       cd;
  logic       nw;
  logic       l2d;
  logic       uc;
  logic       lk;
  logic       wk;
  logic [2:0] beats;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // copy of control bits, taken when the write is acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i)
      {l2d, nw, cd} <= 3'h0;
    else if (wb_ack_o && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == cfr_pkg::REG_CTRL)
      {l2d, nw, cd} <= wb_dat_i[2:0];
  end

  // kind of the access in flight, dropped when it completes
  always_ff @(posedge clk_i) begin
    if (rst_i || req_done_o)
      {uc, lk, wk} <= 3'h0;
    else if (req_i)
      {uc, lk, wk} <= {req_uncache_i, req_locked_i, req_walk_i};
  end

  // ready strobes seen during one burst fill
  always_ff @(posedge clk_i) begin
    if (rst_i || !line_fill_intent_o)
      beats <= 3'h0;
    else if (!burst_ready_n_i)
      beats <= beats + 3'h1;
  end

  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("register access not answered");
  chk_fack_pulse: assert property (
    flush_ack_cycle_o |=> !flush_ack_cycle_o) else $error("long flush ack");
  chk_l2d_quiet: assert property (
    l2d |-> !(l2_fill_o || l2_shared_o || l2_mark_mod_o))
    else $error("second level touched while disabled");
  chk_cd_nofill: assert property (
    cd && !nw |-> !l1_fill_o && !l2_fill_o) else $error("fill while disabled");
  chk_lock_uncached: assert property (
    lk |-> !l1_fill_o && !line_fill_intent_o) else $error("locked cached");
  chk_walk_no_l1: assert property (
    wk |-> !l1_fill_o) else $error("table walk placed in first level");
  chk_uc_no_burst: assert property (
    uc |-> !line_fill_intent_o && !l2_fill_o) else $error("uncacheable filled");
  chk_beat_limit: assert property (
    line_fill_intent_o && !burst_ready_n_i |-> beats < 3'h4)
    else $error("burst longer than four beats");

  cover property (line_fill_intent_o && !burst_ready_n_i && beats == 3'h3);
  cover property (flush_ack_cycle_o);
  cover property (l2_mark_mod_o);
endmodule // cfr_ctrl_chk

bind cfr_ctrl cfr_ctrl_chk i_cfr_ctrl_chk (.*);

// ===== verif/cfr_bus_model.sv
/* cfr_bus_model: system logic on the far side of the processor bus.
   Answers each bus cycle with ready strobes, four for a line fill,
   and may refuse caching. Assumes one clock shared with the design. */
`timescale 1ns/1ps
module cfr_bus_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic intent_i,
  input  wire logic refuse_i,
  input  wire logic slow_i,
  output logic      burst_ready_n_o,
  output logic      next_address_n_o,
  output logic      cacheable_ack_n_o
);
  logic       act;
  logic [1:0] wt;
  logic [2:0] n;

  // one strobe a beat; acknowledge toggles where it carries nothing
  always_ff @(posedge clk_i) begin
    burst_ready_n_o <= 1'b1;
    next_address_n_o <= 1'b1;
    cacheable_ack_n_o <= ~cacheable_ack_n_o;
    if (rst_i) begin
      act <= 1'b0;
      cacheable_ack_n_o <= 1'b1;
    end else if (start_i) begin
      act <= 1'b1;
      wt <= slow_i ? 2'h3 : 2'h0;
      n <= 3'h0;
    end else if (act && wt != 2'h0) begin
      wt <= wt - 2'h1;
    end else if (act) begin
      burst_ready_n_o <= 1'b0;
      wt <= slow_i ? 2'h2 : 2'h0;
      n <= n + 3'h1;
      if (n == 3'h0) cacheable_ack_n_o <= refuse_i;
      if (n == 3'h3 || !intent_i || refuse_i) act <= 1'b0;
    end
  end
endmodule // cfr_bus_model

// ===== verif/tb_top.sv
/* tb_top: self-checking bench for cfr_ctrl with the bus model.
   Assumes lookup inputs stay steady through each access. */
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 0, rst_i = 1, flush_n_i = 1, req_i = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_policy_i = 1;
  logic        req_we_i = 0, req_locked_i = 0, req_walk_i = 0;
  logic        req_uncache_i = 0, req_wa_ok_i = 0, req_instr_i = 0;
  logic        l1_tag_hit_i = 0, l1_line_valid_i = 0, l1_victim_mod_i = 0;
  logic        l1_other_mod_i = 0, l2_hit_i = 0, refuse = 0, slow = 0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, req_adr_i = 32'h0000_3000, r;
  logic        dirty_left_i, lines_left_i, burst_ready_n_i, next_address_n_i;
  logic        cacheable_ack_n_i, wb_ack_o, bus_start_o, bus_we_o;
  logic        line_fill_intent_o, flush_ack_cycle_o, l1_fill_o;
  logic        l1_inv_other_o, l1_merge_o, l2_fill_o, l2_shared_o;
  logic        l2_mark_mod_o, step_wb_o, step_inv_o, page_mode_o;
  logic        use_lru_o, req_done_o;
  logic [31:0] wb_dat_o, bus_adr_o;
  logic [1:0]  victim_way_o;
  logic [10:0] ev;
  int          rd = 0, rl = 0, err_count = 0, checks = 0;
  int          c[11] = '{default: 0}, s[11], d[11];

  cfr_ctrl #(.WAYS(2)) i_cfr_ctrl (.*);
  cfr_bus_model i_cfr_bus_model (.clk_i, .rst_i, .start_i(bus_start_o),
    .intent_i(line_fill_intent_o), .refuse_i(refuse), .slow_i(slow),
    .burst_ready_n_o(burst_ready_n_i), .next_address_n_o(next_address_n_i),
    .cacheable_ack_n_o(cacheable_ack_n_i));

  always #25 clk_i = ~clk_i;
  // a step seen this cycle already consumes one unit of work
  assign dirty_left_i = rd > int'(step_wb_o);
  assign lines_left_i = rl > int'(step_inv_o);
  assign ev = {l2_shared_o, page_mode_o, bus_start_o & bus_we_o,
    flush_ack_cycle_o, step_inv_o, step_wb_o, l2_mark_mod_o,
    l1_inv_other_o, l2_fill_o, l1_fill_o, !burst_ready_n_i};

  // event counters; flush work shrinks with every step pulse
  always @(posedge clk_i) begin
    foreach (c[i]) if (ev[i]) c[i] <= c[i] + 1;
    if (step_wb_o && rd > 0) rd <= rd - 1;
    if (step_inv_o && rl > 0) rl <= rl - 1;
  end

  task end_of_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string n, logic [31:0] v, logic [31:0] e);
    checks++;
    if (v !== e) begin
      err_count++;
      $display("MISMATCH %s exp %0h seen %0h", n, e, v);
    end
  endtask
  task fail;
    chk("wait", 0, 1);
    end_of_test;
  endtask
  // classic single cycle, held until ack is seen at an edge
  task wb(logic we, logic [3:0] a, logic [31:0] w);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= w;
    @(posedge clk_i);
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 20) fail;
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // bits: we lock walk uncache wa_ok instr tag vmod omod l2hit
  task set(logic [9:0] f);
    {req_we_i, req_locked_i, req_walk_i, req_uncache_i, req_wa_ok_i,
     req_instr_i, l1_tag_hit_i, l1_victim_mod_i, l1_other_mod_i,
     l2_hit_i} <= f;
  endtask
  // one access or one flush request, counted until done
  task go(logic fl);
    int i;
    s = c;
    @(posedge clk_i);
    if (fl) flush_n_i <= 1'b0;
    else req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    for (i = 0; i < 300 && (fl ? flush_ack_cycle_o : req_done_o) !== 1'b1;
         i++) @(posedge clk_i);
    if (i == 300) fail;
    flush_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    foreach (d[k]) d[k] = c[k] - s[k];
  endtask
  // register command, then poll the busy flag
  task cmd(logic [3:0] a, logic [31:0] w);
    int i;
    s = c;
    wb(1'b1, a, w);
    for (i = 0; i < 40; i++) begin
      wb(1'b0, cfr_pkg::REG_STATUS, 32'h0);
      if (r[4] === 1'b0) break;
    end
    if (i == 40) fail;
    foreach (d[k]) d[k] = c[k] - s[k];
  endtask

  task t_regs;
    wb(1'b0, cfr_pkg::REG_CTRL, 32'h0);
    chk("ctrl", r, 32'h0);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", r, 32'h0);
  endtask
  // tag miss fill, then a slow tag hit instruction fill
  task t_fill;
    set(10'h000);
    go(0);
    chk("beats", d[0], 4);
    chk("l1", d[1], 1);
    chk("l2", d[2], 1);
    chk("inv", d[3], 1);
    slow <= 1'b1;
    set(10'h018);
    go(0);
    chk("beats", d[0], 4);
    chk("inv", d[3], 0);
    chk("way", victim_way_o, 32'h2);
    slow <= 1'b0;
  endtask
  // modified victims: into L2 on a hit, onto the bus on a miss
  task t_victim;
    set(10'h007);
    go(0);
    chk("beats", d[0], 0);
    chk("l1", d[1], 1);
    chk("mark", d[4], 2);
    set(10'h004);
    go(0);
    chk("wb", d[5], 1);
    chk("mark", d[4], 0);
  endtask
  task t_uncached;
    set(10'h040);
    go(0);
    chk("beats", d[0], 1);
    chk("l1", d[1], 0);
    set(10'h100);
    go(0);
    chk("beats", d[0], 1);
    set(10'h080);
    go(0);
    chk("l1", d[1], 0);
    chk("l2", d[2], 1);
  endtask
  task t_refused;
    refuse <= 1'b1;
    set(10'h000);
    go(0);
    chk("beats", d[0], 1);
    chk("l1", d[1], 0);
    set(10'h220);
    go(0);
    chk("wr", d[8], 1);
    chk("l2", d[2], 0);
    refuse <= 1'b0;
  endtask
  task t_alloc;
    wb_policy_i <= 1'b0;
    set(10'h220);
    go(0);
    chk("beats", d[0], 4);
    chk("shared", d[10], 1);
    wb_policy_i <= 1'b1;
    set(10'h221);
    go(0);
    chk("beats", d[0], 0);
    set(10'h200);
    go(0);
    chk("wr", d[8], 1);
    chk("l1", d[1], 0);
  endtask
  task t_flush;
    rd <= 3;
    rl <= 2;
    go(1);
    chk("wb", d[5], 3);
    chk("inv", d[6], 2);
    chk("ack", d[7], 1);
    rd <= 2;
    rl <= 2;
    cmd(cfr_pkg::REG_CTRL, 32'h0000_0100);
    chk("wb", d[5], 2);
    chk("inv", d[6], 2);
    rd <= 2;
    rl <= 2;
    cmd(cfr_pkg::REG_CTRL, 32'h0000_0200);
    chk("wb", d[5], 0);
    chk("inv", d[6], 2);
    rd <= 1;
    rl <= 1;
    cmd(cfr_pkg::REG_PURGE, 32'h0000_5001);
    chk("page", d[9] != 0, 1);
    chk("wb", d[5], 1);
  endtask
  task t_disable;
    wb(1'b1, cfr_pkg::REG_CTRL, 32'h0000_0004);
    wb(1'b0, cfr_pkg::REG_CTRL, 32'h0);
    chk("ctrl", r, 32'h0000_0004);
    set(10'h001);
    go(0);
    chk("beats", d[0], 4);
    chk("l2", d[2], 0);
    rd <= 1;
    rl <= 1;
    cmd(cfr_pkg::REG_CTRL, 32'h0000_0101);
    chk("inv", d[6], 1);
    set(10'h000);
    go(0);
    chk("l1", d[1], 0);
    chk("l2", d[2], 0);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_fill;
    t_victim;
    t_uncached;
    t_refused;
    t_alloc;
    t_flush;
    t_disable;
    end_of_test;
  end
endmodule // tb_top
